// ### bench/lane_capture.sv
// Capture side model: latches the four output lanes at each strobe fall.
// Assumes it runs on the core clock next to the converter block.
`timescale 1ns/1ps
module lane_capture (
  // Clock.
  input  wire logic                 clk_in,
  // Lanes and strobe from the converter.
  input  wire logic                 strobe_in,
  input  wire adc_ctrl_pkg::lanes_t lanes_in,
  // Captured word and its one-cycle marker.
  output adc_ctrl_pkg::lanes_t      word_out,
  output logic                      got_out
);
  logic prev;

  // Latch the lanes where the strobe falls, never on its rise.
  always_ff @(posedge clk_in) begin
    prev    <= strobe_in;
    got_out <= prev && !strobe_in;
    if (prev && !strobe_in) begin
      word_out <= lanes_in;
    end
  end
endmodule

// ### bench/tb.sv
// Self-checking bench for the trim sequencer and the demultiplexed lanes.
// Assumes the design package is compiled before this file.
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] TRIM_N = 32'h0000_0010;
  logic       clk = 0, rst = 1, sclk = 0, trim = 1, sleep = 0, wsel = 0, ext = 0;
  logic       ds = 1, le = 0, sp = 1, wr = 0, rd = 0;
  logic       tact, ods, ole, osp, ph, dcc, rng, stb, got;
  logic [1:0] addr = 0;
  logic [7:0] wd = 0, rdat;
  logic [9:0] il = 0, ql = 0;
  adc_ctrl_pkg::lanes_t lanes, word;
  int         fails = 0, compares = 0, e = 0, lastf = 0, rises = 0, cyc = 0;
  bit         chk = 0, dual = 0, useq = 0, ovr = 0;

  adc_ctrl_top #(
    .STARTUP_SHORT_CYCLES(32'h0000_0014),
    .STARTUP_LONG_CYCLES (32'h0000_0028),
    .TRIM_CYCLES         (TRIM_N),
    .LATENCY             (13)
  ) u_dut (
    .CORE_CLK_IN(clk), .RST_IN(rst), .SAMPLE_CLK_IN(sclk), .I_LEVEL_IN(il), .Q_LEVEL_IN(ql),
    .TRIM_REQUEST_IN(trim), .SLEEP_REQUEST_IN(sleep), .STARTUP_WAIT_SELECT_IN(wsel),
    .EXTENDED_CONTROL_IN(ext), .DRIVE_STRENGTH_SELECT_IN(ds), .LAUNCH_EDGE_SELECT_IN(le),
    .INPUT_SPAN_SELECT_IN(sp), .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_RDATA_OUT(rdat), .TRIM_ACTIVE_OUT(tact), .DRIVE_STRENGTH_OUT(ods),
    .LAUNCH_EDGE_OUT(ole), .INPUT_SPAN_OUT(osp), .PHASE_TRACK_OUT(ph), .DCC_ENABLE_OUT(dcc),
    .LANES_OUT(lanes), .RANGE_EXCEEDED_OUT(rng), .OUTPUT_STROBE_OUT(stb)
  );

  lane_capture u_cap (.clk_in(clk), .strobe_in(stb), .lanes_in(lanes), .word_out(word),
                      .got_out(got));

  // Core clock at 10 MHz and an unrelated 800 ns input clock.
  always #50 clk = ~clk;
  always #400 sclk = ~sclk;

  // Number the input clock edges and give each edge its own level, or an overrange pair.
  always @(sclk) begin
    e++;
    if (!sclk) lastf = e;
    if (sclk && tact) rises++;
    #250;
    il <= ovr ? 10'h1ff : {3'b000, 7'(e + 1)};
    ql <= ovr ? 10'h200 : ~{3'b000, 7'(e + 1)};
  end

  // Offset-binary code of the level set for edge n on either input; overrange clamps.
  function automatic logic [7:0] cd(bit q, int n);
    if (ovr) return q ? 8'h00 : 8'hff;
    return q ? 8'h7f - 8'(n & 127) : 8'h80 + 8'(n & 127);
  endfunction

  // Expected capture, lanes earliest first, for the latest fall index f.
  function automatic logic [32:0] expw(int f);
    bit s;
    s = dual ? useq : 1'b1;
    return {ovr, cd(s, f - (dual ? 31 : 30)), cd(useq, f - 30),
            cd(s, f - (dual ? 29 : 28)), cd(useq, f - 28)};
  endfunction

  // Counts a comparison and reports a mismatch at once.
  task automatic check(logic [32:0] a, logic [32:0] b);
    compares++;
    if (a !== b) begin
      fails++;
      $display("FAIL at %0t: got %h expected %h", $time, a, b);
    end
  endtask

  // Register port: one-cycle strobes, read data in the following cycle.
  task automatic wreg(logic [1:0] a, logic [7:0] d);
    @(posedge clk) begin addr <= a; wd <= d; wr <= 1; end
    @(posedge clk) wr <= 0;
  endtask

  task automatic rreg(logic [1:0] a, logic [7:0] x);
    @(posedge clk) begin addr <= a; rd <= 1; end
    @(posedge clk) rd <= 0;
    #1 check(33'(rdat), 33'(x));
  endtask

  // Drives the trim pin low for lo input rises, then high for hi rises.
  task automatic cmd(int lo, int hi);
    @(posedge clk) trim <= 0;
    repeat (lo) @(posedge sclk);
    repeat (5) @(posedge clk);
    trim <= 1;
    repeat (hi) @(posedge sclk);
  endtask

  // Waits for a trim within lim cycles, then checks its length in rises.
  task automatic expect_trim(bit on, int lim, bit slp);
    int n;
    n = 0;
    rises = 0;
    while (tact !== 1'b1 && n < lim) @(posedge clk) n++;
    check(33'(tact), 33'(on));
    if (tact === 1'b1) begin
      sleep <= slp;
      n = 0;
      while (tact === 1'b1 && n < 400) @(posedge clk) n++;
      check(33'(rises), 33'(TRIM_N));
    end
  endtask

  // Lets the pipeline refill, then compares captured words for a while.
  task automatic run_lanes();
    repeat (40) @(posedge sclk);
    chk = 1;
    repeat (20) @(posedge sclk);
    chk = 0;
  endtask

  // Compares every captured word while a lane test runs.
  always @(posedge clk) begin
    if (got && chk) check({rng, word}, expw(lastf));
  end

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // Main sequence: pin session first, then an extended session, then a pin session with the long wait.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    rreg(2'h0, 8'h60);
    wreg(2'h3, 8'hff);
    rreg(2'h3, 8'h00);
    rreg(2'h2, 8'h00);
    check(33'({dcc, ods, ole, osp}), 33'h0_0000_000d);
    $display("test registers done");
    expect_trim(0, 400, 0);
    cmd(9, 10);
    expect_trim(0, 100, 0);
    @(posedge clk) sp <= 0;
    cmd(10, 10);
    expect_trim(1, 100, 0);
    @(posedge clk) sleep <= 1;
    cmd(10, 10);
    expect_trim(0, 100, 0);
    @(posedge clk) sleep <= 0;
    expect_trim(0, 200, 0);
    $display("test trim command done");
    run_lanes();
    ovr = 1;
    run_lanes();
    ovr = 0;
    @(posedge clk) wsel <= 1;
    dual = 1;
    run_lanes();
    check(33'(ph), 33'h0_0000_0001);
    $display("test pin lanes done");
    @(posedge clk) begin rst <= 1; sleep <= 1; trim <= 0; ext <= 1; wsel <= 1; sp <= 1; end
    dual = 0;
    repeat (5) @(posedge clk);
    rst <= 0;
    expect_trim(0, 400, 0);
    @(posedge clk) sleep <= 0;
    expect_trim(0, 140, 0);
    expect_trim(1, 100, 1);
    @(posedge clk) sleep <= 0;
    $display("test startup trim done");
    wreg(2'h0, 8'h7a);
    rreg(2'h0, 8'h7a);
    useq = 1;
    dual = 1;
    run_lanes();
    check(33'({ph, ods, ole, osp}), 33'h0_0000_000a);
    $display("test extended lanes done");
    @(posedge clk) begin rst <= 1; ext <= 0; end
    repeat (5) @(posedge clk);
    rst <= 0;
    expect_trim(0, 300, 0);
    expect_trim(1, 100, 0);
    $display("test long wait done");
    end_of_test();
  end
endmodule

// ### hw/adc_ctrl_defs.svh
// Named constants for the converter control and output sequencing logic.
// Assumes inclusion by bare name from every design file that uses them.
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// Sample input and output code widths.
`define ADC_IN_W           10
`define CODE_W             8

// Trim command qualification, in input clock cycles.
`define TRIM_LOW_MIN       10
`define TRIM_HIGH_MIN      10

// Power-up wait lengths, in input clock cycles.
`define STARTUP_SHORT      32'h0200_0000
`define STARTUP_LONG       32'h8000_0000

// Default trim sequence length, in input clock cycles.
`define TRIM_CYCLES        32'h0000_1000

// Sample-to-output latency of the current lanes, in input clock cycles.
`define LANE_LATENCY       13

// Register port.
`define REG_ADDR_W         2
`define REG_DATA_W         8
`define REG_CONFIG         2'h0
`define REG_STATUS         2'h1
`define CONFIG_RESET       8'h60

// Status register bit positions.
`define STAT_TRIM_BIT      0
`define STAT_SLEEP_BIT     1
`define STAT_BOOTED_BIT    2
`define STAT_EXT_BIT       3

`endif

// ### hw/adc_ctrl_pkg.sv
// Types shared by the converter control and output sequencing logic.
// Assumes the constants header is on the include path.
`include "adc_ctrl_defs.svh"

package adc_ctrl_pkg;

  // One-hot states of the trim sequencer.
  typedef enum logic [3:0] {
    ST_STARTUP = 4'h1,
    ST_IDLE    = 4'h2,
    ST_CAL     = 4'h4,
    ST_SLEEP   = 4'h8
  } cal_state_t;

  // One converted sample pair as it travels down the pipeline.
  typedef struct packed {
    logic [`CODE_W-1:0] first;
    logic [`CODE_W-1:0] second;
    logic               oor;
  } entry_t;

  // The four demultiplexed output lanes.
  typedef struct packed {
    logic [`CODE_W-1:0] second_prior;
    logic [`CODE_W-1:0] first_prior;
    logic [`CODE_W-1:0] second_now;
    logic [`CODE_W-1:0] first_now;
  } lanes_t;

  // Software configuration register layout, highest bit first.
  typedef struct packed {
    logic spare;
    logic dcc_enable;
    logic phase_auto;
    logic des_input_q;
    logic des_enable;
    logic span;
    logic launch_edge;
    logic drive_strength;
  } config_t;

endpackage

// ### hw/adc_ctrl_top.sv
// Trim sequencer and demultiplexed output pipeline of a dual converter.
// Assumes pins and the input clock are asynchronous to CORE_CLK_IN.
//
// Contract
// R01: Trim after power-up and on each command.
// R02: Controller recommands trim after span change.
// R03: Controller waits 20 s before best trim.
// R04: No trim start or run while sleeping.
// R05: Command is ten low then ten high.
// R06: Request high at power-up suppresses startup trim.
// R07: Startup wait is 2^25 or 2^31 cycles.
// R08: Sleep at power-up holds the wait counter.
// R09: Trim active high for whole trim.
// R10: Outputs 13 and 14 cycles after sampling.
// R11: Offset-binary 8-bit codes, converting continuously.
// R12: Extended control takes settings from register.
// R13: Controller fixes control mode for session.
// R14: Dual-edge mode samples both clock edges.
// R15: Four lanes ordered earliest to latest.
// R16: Dual-edge input is I unless extended choice.
// R17: Second lanes carry rise samples 13.5/14.5.
// R18: Normal mode: first is I, second Q.
// R19: Background phase tracking in dual-edge mode.
// R20: Duty-cycle correction enabled after power-up.
// R21: Output strobe; lanes referenced to its fall.
// R22: Clamp codes and flag out of range.
// R23: Sleep during trim waits for trim end.
// R24: Commands during sleep are discarded.
// R25: Trim length is a configurable cycle count.
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"

module adc_ctrl_top #(
  parameter logic [31:0] STARTUP_SHORT_CYCLES = `STARTUP_SHORT,
  parameter logic [31:0] STARTUP_LONG_CYCLES  = `STARTUP_LONG,
  parameter logic [31:0] TRIM_CYCLES          = `TRIM_CYCLES,
  parameter int          LATENCY              = `LANE_LATENCY
) (
  // Clock and reset.
  input  wire logic                      CORE_CLK_IN,
  input  wire logic                      RST_IN,
  // Input sample clock and converted analog levels.
  input  wire logic                      SAMPLE_CLK_IN,
  input  wire logic [`ADC_IN_W-1:0]      I_LEVEL_IN,
  input  wire logic [`ADC_IN_W-1:0]      Q_LEVEL_IN,
  // Control pins.
  input  wire logic                      TRIM_REQUEST_IN,
  input  wire logic                      SLEEP_REQUEST_IN,
  input  wire logic                      STARTUP_WAIT_SELECT_IN,
  input  wire logic                      EXTENDED_CONTROL_IN,
  input  wire logic                      DRIVE_STRENGTH_SELECT_IN,
  input  wire logic                      LAUNCH_EDGE_SELECT_IN,
  input  wire logic                      INPUT_SPAN_SELECT_IN,
  // Register port.
  input  wire logic [`REG_ADDR_W-1:0]    REG_ADDR_IN,
  input  wire logic [`REG_DATA_W-1:0]    REG_WDATA_IN,
  input  wire logic                      REG_WR_IN,
  input  wire logic                      REG_RD_IN,
  output logic      [`REG_DATA_W-1:0]    REG_RDATA_OUT,
  // Status and effective settings.
  output logic                           TRIM_ACTIVE_OUT,
  output logic                           DRIVE_STRENGTH_OUT,
  output logic                           LAUNCH_EDGE_OUT,
  output logic                           INPUT_SPAN_OUT,
  output logic                           PHASE_TRACK_OUT,
  output logic                           DCC_ENABLE_OUT,
  // Output lanes.
  output adc_ctrl_pkg::lanes_t           LANES_OUT,
  output logic                           RANGE_EXCEEDED_OUT,
  output logic                           OUTPUT_STROBE_OUT
);

  localparam int PIN_W = 8 + 2 * `ADC_IN_W;

  logic [PIN_W-1:0]          pin_meta;
  logic [PIN_W-1:0]          pin_sync;
  logic                      sclk_d;
  logic                      rise;
  logic                      fall;
  logic [`ADC_IN_W-1:0]      i_s;
  logic [`ADC_IN_W-1:0]      q_s;
  logic                      sclk_s;
  logic                      trim_s;
  logic                      sleep_s;
  logic                      wait_s;
  logic                      ext_s;
  logic                      drive_s;
  logic                      launch_s;
  logic                      span_s;
  adc_ctrl_pkg::config_t     cfg;
  adc_ctrl_pkg::cal_state_t  state;
  adc_ctrl_pkg::cal_state_t  next_state;
  logic [31:0]               wait_cnt;
  logic [31:0]               wait_last;
  logic [31:0]               cal_cnt;
  logic                      booted;
  logic                      suppress;
  logic                      cmd;
  logic                      startup_done;
  logic                      cal_done;
  logic                      des;
  logic                      des_q;
  adc_ctrl_pkg::entry_t      pipe [LATENCY+1];
  adc_ctrl_pkg::entry_t      tap_now;
  adc_ctrl_pkg::entry_t      tap_prior;
  logic [`CODE_W:0]          rise_hold;
  logic [`CODE_W:0]          enc_i;
  logic [`CODE_W:0]          enc_sel;
  logic [`CODE_W:0]          enc_q;
  logic                      phase;
  logic                      lanes_update;

  // Clamps a two's complement level to an offset-binary code with an overrange bit.
  function automatic logic [`CODE_W:0] encode(input logic [`ADC_IN_W-1:0] v);
    logic [`ADC_IN_W-`CODE_W:0] hi;
    logic                        oor;
    hi  = v[`ADC_IN_W-1:`CODE_W-1];
    oor = !((&hi) || !(|hi));
    if (!oor) begin
      encode = {1'b0, ~v[`CODE_W-1], v[`CODE_W-2:0]};
    end else if (v[`ADC_IN_W-1]) begin
      encode = {1'b1, {`CODE_W{1'b0}}};
    end else begin
      encode = {1'b1, {`CODE_W{1'b1}}};
    end
  endfunction

  // Two-stage synchroniser for every pin from outside the core clock domain.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {SAMPLE_CLK_IN, TRIM_REQUEST_IN, SLEEP_REQUEST_IN, STARTUP_WAIT_SELECT_IN,
                   EXTENDED_CONTROL_IN, DRIVE_STRENGTH_SELECT_IN, LAUNCH_EDGE_SELECT_IN,
                   INPUT_SPAN_SELECT_IN, I_LEVEL_IN, Q_LEVEL_IN};
      pin_sync <= pin_meta;
    end
  end

  assign {sclk_s, trim_s, sleep_s, wait_s, ext_s, drive_s, launch_s, span_s, i_s, q_s} = pin_sync;

  // Edge finder on the synchronised input clock.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  assign rise = sclk_s && !sclk_d;
  assign fall = !sclk_s && sclk_d;

  // Software configuration register; duty-cycle correction resets enabled.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      cfg <= `CONFIG_RESET; // R20
    end else if (REG_WR_IN && REG_ADDR_IN == `REG_CONFIG) begin
      cfg <= REG_WDATA_IN;
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= '0;
    end else begin
      REG_RDATA_OUT <= '0;
      if (REG_RD_IN && REG_ADDR_IN == `REG_CONFIG) begin
        REG_RDATA_OUT <= cfg;
      end else if (REG_RD_IN && REG_ADDR_IN == `REG_STATUS) begin
        REG_RDATA_OUT[`STAT_TRIM_BIT]   <= TRIM_ACTIVE_OUT;
        REG_RDATA_OUT[`STAT_SLEEP_BIT]  <= state == adc_ctrl_pkg::ST_SLEEP;
        REG_RDATA_OUT[`STAT_BOOTED_BIT] <= state != adc_ctrl_pkg::ST_STARTUP;
        REG_RDATA_OUT[`STAT_EXT_BIT]    <= ext_s;
      end
    end
  end

  // Pins or register steer the mode; the wait select pin doubles as dual-edge enable.
  assign des   = ext_s ? cfg.des_enable : wait_s; // R12
  assign des_q = ext_s && cfg.des_input_q; // R16

  // Effective analog settings, pin or register depending on control mode; duty-cycle correction always from register.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      DRIVE_STRENGTH_OUT <= 1'b0;
      LAUNCH_EDGE_OUT    <= 1'b0;
      INPUT_SPAN_OUT     <= 1'b0;
      PHASE_TRACK_OUT    <= 1'b0;
      DCC_ENABLE_OUT     <= 1'b1; // R20
    end else begin
      DRIVE_STRENGTH_OUT <= ext_s ? cfg.drive_strength : drive_s; // R12
      LAUNCH_EDGE_OUT    <= ext_s ? cfg.launch_edge : launch_s; // R12
      INPUT_SPAN_OUT     <= ext_s ? cfg.span : span_s; // R12
      PHASE_TRACK_OUT    <= des && (!ext_s || cfg.phase_auto); // R19
      DCC_ENABLE_OUT     <= cfg.dcc_enable; // R20
    end
  end

  // Command qualifier, held cleared whenever sleep is requested or entered.
  trim_cmd_detect #(
    .LOW_MIN  (`TRIM_LOW_MIN),
    .HIGH_MIN (`TRIM_HIGH_MIN)
  ) u_cmd (
    .clk_in   (CORE_CLK_IN),
    .rst_in   (RST_IN),
    .edge_in  (rise),
    .level_in (trim_s),
    .clear_in (sleep_s || state == adc_ctrl_pkg::ST_SLEEP), // R24
    .cmd_out  (cmd)
  );

  // The request level at the first input clock rise after reset decides suppression.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      booted   <= 1'b0;
      suppress <= 1'b0;
    end else if (rise && !booted) begin
      booted   <= 1'b1;
      suppress <= trim_s; // R06
    end
  end

  // Extended control always takes the short wait.
  assign wait_last = ((wait_s && !ext_s) ? STARTUP_LONG_CYCLES : STARTUP_SHORT_CYCLES) - 1'b1;

  // Power-up wait counter, frozen while sleep is requested.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      wait_cnt <= '0;
    end else if (state == adc_ctrl_pkg::ST_STARTUP && rise && !sleep_s) begin
      wait_cnt <= wait_cnt + 1'b1; // R07 R08
    end
  end

  assign startup_done = state == adc_ctrl_pkg::ST_STARTUP && rise && !sleep_s &&
                        wait_cnt == wait_last; // R07

  // Trim length counter, counting input clock cycles while trimming.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || state != adc_ctrl_pkg::ST_CAL) begin
      cal_cnt <= '0;
    end else if (rise) begin
      cal_cnt <= cal_cnt + 1'b1; // R25
    end
  end

  assign cal_done = state == adc_ctrl_pkg::ST_CAL && rise && cal_cnt == TRIM_CYCLES - 1'b1;

  // Sequencer transitions; sleep beats a command, and a running trim is never cut.
  always_comb begin
    next_state = state;
    unique case (state)
      adc_ctrl_pkg::ST_STARTUP: begin
        if (cmd && !sleep_s) begin
          next_state = adc_ctrl_pkg::ST_CAL; // R01 R04
        end else if (startup_done) begin
          next_state = suppress ? adc_ctrl_pkg::ST_IDLE : adc_ctrl_pkg::ST_CAL; // R01 R06
        end
      end
      adc_ctrl_pkg::ST_IDLE: begin
        if (sleep_s) begin
          next_state = adc_ctrl_pkg::ST_SLEEP; // R04
        end else if (cmd) begin
          next_state = adc_ctrl_pkg::ST_CAL; // R01
        end
      end
      adc_ctrl_pkg::ST_CAL: begin
        if (cal_done) begin
          next_state = sleep_s ? adc_ctrl_pkg::ST_SLEEP : adc_ctrl_pkg::ST_IDLE; // R23
        end
      end
      adc_ctrl_pkg::ST_SLEEP: begin
        if (!sleep_s) begin
          next_state = adc_ctrl_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Sequencer state and the trim active flag, high exactly in the trim state.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      state           <= adc_ctrl_pkg::ST_STARTUP;
      TRIM_ACTIVE_OUT <= 1'b0;
    end else begin
      state           <= next_state;
      TRIM_ACTIVE_OUT <= next_state == adc_ctrl_pkg::ST_CAL; // R09
    end
  end

  // Converter codes for the first, selected and second inputs.
  assign enc_i   = encode(i_s); // R11 R22
  assign enc_sel = encode(des_q ? q_s : i_s); // R16
  assign enc_q   = encode(q_s); // R18

  // Rise-edge converter in dual-edge mode; it enters the pipe at the next fall.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      rise_hold <= '0;
    end else if (rise) begin
      rise_hold <= enc_sel; // R14 R17
    end
  end

  // Sample pipeline, advanced on every input clock fall.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      for (int k = 0; k <= LATENCY; k++) begin
        pipe[k] <= '0;
      end
    end else if (fall) begin
      pipe[0].first  <= des ? enc_sel[`CODE_W-1:0] : enc_i[`CODE_W-1:0]; // R14 R18
      pipe[0].second <= des ? rise_hold[`CODE_W-1:0] : enc_q[`CODE_W-1:0]; // R17 R18
      pipe[0].oor    <= des ? (enc_sel[`CODE_W] || rise_hold[`CODE_W]) :
                              (enc_i[`CODE_W] || enc_q[`CODE_W]); // R22
      for (int k = 1; k <= LATENCY; k++) begin
        pipe[k] <= pipe[k-1];
      end
    end
  end

  assign tap_now      = pipe[LATENCY-1];
  assign tap_prior    = pipe[LATENCY];
  assign lanes_update = fall && phase;

  // Demultiplex phase and strobe; the strobe falls one sample after the lanes change.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      phase             <= 1'b0;
      OUTPUT_STROBE_OUT <= 1'b0;
    end else if (fall) begin
      phase             <= !phase;
      OUTPUT_STROBE_OUT <= phase; // R21
    end
  end

  // Lane registers, loaded every second fall in earliest-to-latest order.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      LANES_OUT          <= '0;
      RANGE_EXCEEDED_OUT <= 1'b0;
    end else if (lanes_update) begin
      LANES_OUT.first_now    <= tap_now.first; // R10 R15
      LANES_OUT.second_now   <= tap_now.second; // R10 R15
      LANES_OUT.first_prior  <= tap_prior.first; // R10 R15
      LANES_OUT.second_prior <= tap_prior.second; // R10 R15
      RANGE_EXCEEDED_OUT     <= tap_now.oor || tap_prior.oor; // R22
    end
  end

  // Trim only begins from a command or the end of the power-up wait.
  trim_start_cause_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R01
    $rose(TRIM_ACTIVE_OUT) |-> $past(cmd) || $past(startup_done))
    else $error("Trim began without a cause.");

  // A sleep request keeps an idle sequencer from trimming.
  sleep_no_start_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R04
    sleep_s && state != adc_ctrl_pkg::ST_CAL ##1 sleep_s |-> !TRIM_ACTIVE_OUT)
    else $error("Trim started while sleep was requested.");

  // Startup goes to idle only when suppressed.
  startup_suppress_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R06
    $past(state) == adc_ctrl_pkg::ST_STARTUP && state == adc_ctrl_pkg::ST_IDLE |->
    $past(suppress))
    else $error("Startup went idle without suppression.");

  // The wait ends only after the full count.
  startup_length_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R07
    $past(state) == adc_ctrl_pkg::ST_STARTUP && state == adc_ctrl_pkg::ST_CAL && !$past(cmd)
    |-> $past(wait_cnt) == $past(wait_last))
    else $error("Startup wait ended early.");

  // Sleep freezes the wait counter.
  startup_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R08
    sleep_s |=> $stable(wait_cnt))
    else $error("Wait counter moved during sleep.");

  // Trim lasts exactly the configured count.
  trim_length_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R25
    $fell(TRIM_ACTIVE_OUT) |-> $past(cal_cnt) == TRIM_CYCLES - 1'b1)
    else $error("Trim ended at the wrong count.");

  // A pending sleep is entered exactly when trim ends.
  sleep_after_trim_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R23
    $fell(TRIM_ACTIVE_OUT) && $past(sleep_s) |-> state == adc_ctrl_pkg::ST_SLEEP)
    else $error("Sleep not entered after trim.");

  // A current and a prior lane take the pipeline taps of the right age.
  lane_latency_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R10
    lanes_update |=> LANES_OUT.first_now == $past(tap_now.first) &&
                     LANES_OUT.second_prior == $past(tap_prior.second))
    else $error("Lane latency mismatch.");

  // Lanes change only together with a rising strobe.
  strobe_ref_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R21
    $changed(LANES_OUT) |-> $rose(OUTPUT_STROBE_OUT))
    else $error("Lanes changed away from the strobe.");

  // Extended mode follows the register, not the pin.
  ext_select_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R12
    ext_s |=> DRIVE_STRENGTH_OUT == $past(cfg.drive_strength))
    else $error("Pin setting used in extended mode.");

endmodule

// ### hw/trim_cmd_detect.sv
// Qualifies the trim request pin: a long enough low then high phase.
// Assumes a level already synchronised and a one-cycle input clock edge enable.
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"

module trim_cmd_detect #(
  parameter int LOW_MIN  = `TRIM_LOW_MIN,
  parameter int HIGH_MIN = `TRIM_HIGH_MIN
) (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Qualification inputs.
  input  wire logic edge_in,
  input  wire logic level_in,
  input  wire logic clear_in,
  // Result.
  output logic      cmd_out
);

  localparam int CW = $clog2((LOW_MIN > HIGH_MIN ? LOW_MIN : HIGH_MIN) + 1);
  localparam logic [CW-1:0] LOW_FULL  = CW'(LOW_MIN);
  localparam logic [CW-1:0] HIGH_LAST = CW'(HIGH_MIN - 1);

  logic [CW-1:0] low_cnt;
  logic [CW-1:0] high_cnt;
  logic          armed;

  // A level held high from power-up is never armed, so it needs a low phase first.
  always_ff @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      low_cnt  <= '0;
      high_cnt <= '0;
      armed    <= 1'b0;
      cmd_out  <= 1'b0;
    end else begin
      cmd_out <= 1'b0;
      if (edge_in && !level_in) begin
        high_cnt <= '0;
        armed    <= 1'b0;
        if (low_cnt != LOW_FULL) begin
          low_cnt <= low_cnt + 1'b1; // R05
        end
      end else if (edge_in && (armed || low_cnt == LOW_FULL)) begin
        low_cnt <= '0;
        if (high_cnt == HIGH_LAST) begin
          cmd_out  <= 1'b1; // R05
          armed    <= 1'b0;
          high_cnt <= '0;
        end else begin
          armed    <= 1'b1;
          high_cnt <= high_cnt + 1'b1;
        end
      end else if (edge_in) begin
        low_cnt <= '0;
      end
    end
  end

  // A command is only reported at the last of the required high cycles.
  cmd_high_len_a: assert property (@(posedge clk_in) disable iff (rst_in) // R05
    cmd_out |-> $past(high_cnt) == HIGH_LAST && $past(level_in))
    else $error("Trim command reported without a full high phase.");

  // While cleared no command can come out.
  cmd_cleared_a: assert property (@(posedge clk_in) disable iff (rst_in) // R24
    clear_in |=> !cmd_out)
    else $error("Trim command reported while cleared.");

endmodule
